// >>> bal_byte_adder.sv
`timescale 1ns/1ps
// Add or subtract with borrow-in; gives half carry and overflow as well
module bal_byte_adder (
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic cin,
	input wire logic subtract,
	output logic [7:0] sum,
	output logic carry,
	output logic half,
	output logic ovf
);
	logic [4:0] low;
	logic [8:0] full;
	logic [7:0] b_eff;

	always_comb begin
		b_eff = subtract ? ~b : b;
		// Subtract as a + ~b + ~borrow
		low = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin ^ subtract};
		full = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin ^ subtract};
		sum = full[7:0];
		carry = full[8] ^ subtract;
		half = low[4] ^ subtract;
		ovf = (a[7] == b_eff[7]) && (sum[7] != a[7]);
	end
endmodule // bal_byte_adder

// >>> bal_core.sv
`timescale 1ns/1ps
// Behaviour
// - Register add, optional carry, five flags, one clock
// - Pair add immediate, ZCNVS flags, two clocks
// - Register subtract, optional carry, five flags
// - Immediate subtract, optional carry, five flags
// - Pair subtract immediate, ZCNVS, two clocks
// - AND register or immediate, flags ZNV
// - OR register/immediate, XOR registers, flags ZNV
// - Invert destination, flags ZCNV, carry set
module bal_core (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic start,
	input wire logic [bal_pkg::OP_W-1:0] op,
	input wire logic [7:0] dest_reg,
	input wire logic [7:0] source_reg,
	input wire logic [7:0] dest_high_reg,
	input wire logic [7:0] immediate,
	output logic [7:0] result,
	output logic [7:0] result_high,
	output logic result_valid,
	output logic result_pair,
	output logic busy,
	output logic [7:0] flags
);
	bal_pkg::bal_state_e state, next_state;
	logic [7:0] next_result, next_result_high, next_flags;
	logic next_result_valid, next_result_pair, next_busy;
	logic [7:0] low_sum, pair_low;
	logic pair_carry, pair_sub, next_pair_carry, next_pair_sub;
	logic [7:0] next_pair_low, next_pair_high_in;
	logic [7:0] pair_high_in;
	logic [7:0] add_a, add_b, add_s;
	logic add_cin, add_sub, add_c, add_h, add_v;
	logic [7:0] logic_r;
	logic [15:0] pair_word;

	always_comb begin
		add_a = dest_reg;
		add_b = source_reg;
		add_cin = 1'b0;
		add_sub = 1'b0;
		if (state == bal_pkg::BAL_PAIR_HIGH) begin
			// Second cycle: high byte with carry/borrow from the low byte
			add_a = pair_high_in;
			add_b = 8'h00;
			add_cin = pair_carry;
			add_sub = pair_sub;
		end else begin
			case (op)
				bal_pkg::OP_ADD_CARRY: add_cin = flags[bal_pkg::FLAG_C];
				bal_pkg::OP_SUB: add_sub = 1'b1;
				bal_pkg::OP_DIFFERENCE_MINUS_CARRY: begin
					add_sub = 1'b1;
					add_cin = flags[bal_pkg::FLAG_C];
				end
				bal_pkg::OP_DIFFERENCE_IMMEDIATE: begin
					add_sub = 1'b1;
					add_b = immediate;
				end
				bal_pkg::OP_DIFFERENCE_IMM_MINUS_CARRY: begin
					add_sub = 1'b1;
					add_b = immediate;
					add_cin = flags[bal_pkg::FLAG_C];
				end
				bal_pkg::OP_PAIR_INCREMENT_BY_IMM: add_b = immediate;
				bal_pkg::OP_PAIR_DECREMENT_BY_IMM: begin
					add_sub = 1'b1;
					add_b = immediate;
				end
				default: ;
			endcase
		end
	end

	bal_byte_adder u_adder (
		.a(add_a),
		.b(add_b),
		.cin(add_cin),
		.subtract(add_sub),
		.sum(add_s),
		.carry(add_c),
		.half(add_h),
		.ovf(add_v)
	);

	always_comb begin
		case (op)
			bal_pkg::OP_AND, bal_pkg::OP_CONJUNCTION_IMMEDIATE:
				logic_r = dest_reg & (op == bal_pkg::OP_AND ? source_reg : immediate);
			bal_pkg::OP_OR, bal_pkg::OP_DISJUNCTION_IMMEDIATE:
				logic_r = dest_reg | (op == bal_pkg::OP_OR ? source_reg : immediate);
			bal_pkg::OP_EXCLUSIVE_DISJUNCTION: logic_r = dest_reg ^ source_reg;
			default: logic_r = bal_pkg::ALL_ONES - dest_reg;
		endcase
	end

	assign low_sum = add_s;
	assign pair_word = {add_s, pair_low};

	always_comb begin
		next_state = state;
		next_result = result;
		next_result_high = result_high;
		next_flags = flags;
		next_result_valid = 1'b0;
		next_result_pair = 1'b0;
		next_busy = busy;
		next_pair_low = pair_low;
		next_pair_carry = pair_carry;
		next_pair_sub = pair_sub;
		next_pair_high_in = pair_high_in;
		case (state)
			bal_pkg::BAL_IDLE: begin
				if (start) begin
					case (op)
						bal_pkg::OP_ADD, bal_pkg::OP_ADD_CARRY, bal_pkg::OP_SUB, bal_pkg::OP_DIFFERENCE_IMMEDIATE,
						bal_pkg::OP_DIFFERENCE_MINUS_CARRY, bal_pkg::OP_DIFFERENCE_IMM_MINUS_CARRY: begin
							next_result = low_sum;
							next_result_valid = 1'b1;
							next_flags[bal_pkg::FLAG_C] = add_c;
							next_flags[bal_pkg::FLAG_H] = add_h;
							next_flags[bal_pkg::FLAG_V] = add_v;
							next_flags[bal_pkg::FLAG_N] = low_sum[7];
							next_flags[bal_pkg::FLAG_Z] = (low_sum == 8'h00);
						end
						bal_pkg::OP_PAIR_INCREMENT_BY_IMM, bal_pkg::OP_PAIR_DECREMENT_BY_IMM: begin
							// Low byte now, high byte next cycle
							next_pair_low = low_sum;
							next_pair_carry = add_c;
							next_pair_sub = add_sub;
							next_pair_high_in = dest_high_reg;
							next_busy = 1'b1;
							next_state = bal_pkg::BAL_PAIR_HIGH;
						end
						bal_pkg::OP_AND, bal_pkg::OP_CONJUNCTION_IMMEDIATE, bal_pkg::OP_OR,
						bal_pkg::OP_DISJUNCTION_IMMEDIATE, bal_pkg::OP_EXCLUSIVE_DISJUNCTION: begin
							next_result = logic_r;
							next_result_valid = 1'b1;
							next_flags[bal_pkg::FLAG_V] = 1'b0;
							next_flags[bal_pkg::FLAG_N] = logic_r[7];
							next_flags[bal_pkg::FLAG_Z] = (logic_r == 8'h00);
						end
						bal_pkg::OP_INVERT_ALL_BITS: begin
							next_result = logic_r;
							next_result_valid = 1'b1;
							next_flags[bal_pkg::FLAG_C] = 1'b1;
							next_flags[bal_pkg::FLAG_V] = 1'b0;
							next_flags[bal_pkg::FLAG_N] = logic_r[7];
							next_flags[bal_pkg::FLAG_Z] = (logic_r == 8'h00);
						end
						default: ;
					endcase
				end
			end
			bal_pkg::BAL_PAIR_HIGH: begin
				next_result = pair_low;
				next_result_high = add_s;
				next_result_valid = 1'b1;
				next_result_pair = 1'b1;
				next_busy = 1'b0;
				next_flags[bal_pkg::FLAG_C] = add_c;
				// Word overflow: sign flip against the operand high byte
				next_flags[bal_pkg::FLAG_V] = pair_sub ? (pair_high_in[7] & ~add_s[7]) : (~pair_high_in[7] & add_s[7]);
				next_flags[bal_pkg::FLAG_N] = add_s[7];
				next_flags[bal_pkg::FLAG_Z] = (pair_word == 16'h0000);
				next_flags[bal_pkg::FLAG_S] = add_s[7] ^ next_flags[bal_pkg::FLAG_V];
				next_state = bal_pkg::BAL_IDLE;
			end
			default: next_state = bal_pkg::BAL_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= bal_pkg::BAL_IDLE;
			result <= 8'h00;
			result_high <= 8'h00;
			result_valid <= 1'b0;
			result_pair <= 1'b0;
			busy <= 1'b0;
			flags <= bal_pkg::FLAGS_RESET;
			pair_low <= 8'h00;
			pair_carry <= 1'b0;
			pair_sub <= 1'b0;
			pair_high_in <= 8'h00;
		end else if (clk_en) begin
			state <= next_state;
			result <= next_result;
			result_high <= next_result_high;
			result_valid <= next_result_valid;
			result_pair <= next_result_pair;
			busy <= next_busy;
			flags <= next_flags;
			pair_low <= next_pair_low;
			pair_carry <= next_pair_carry;
			pair_sub <= next_pair_sub;
			pair_high_in <= next_pair_high_in;
		end
	end

	sequence s_pair_start;
		start && clk_en && !busy && (op == bal_pkg::OP_PAIR_INCREMENT_BY_IMM || op == bal_pkg::OP_PAIR_DECREMENT_BY_IMM);
	endsequence

	// Only an enabled second cycle finishes the pair; a frozen one just delays it
	sequence s_pair_second;
		s_pair_start ##1 clk_en;
	endsequence

	a_add_result: assert property (@(posedge clk_sys) disable iff (!rst_n)
		start && clk_en && !busy && op == bal_pkg::OP_ADD |=> result_valid && result == $past(dest_reg) + $past(source_reg))
		else $error("Register add result wrong");
	a_pair_two_clk: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_pair_second |=> result_valid && result_pair && !busy)
		else $error("Pair operation not done in two clocks");
	a_sub_carry: assert property (@(posedge clk_sys) disable iff (!rst_n)
		start && clk_en && !busy && op == bal_pkg::OP_SUB |=> flags[bal_pkg::FLAG_C] == ($past(dest_reg) < $past(source_reg)))
		else $error("Subtract borrow wrong");
	a_difference_immediate_result: assert property (@(posedge clk_sys) disable iff (!rst_n)
		start && clk_en && !busy && op == bal_pkg::OP_DIFFERENCE_IMMEDIATE |=> result == $past(dest_reg) - $past(immediate))
		else $error("Immediate subtract result wrong");
	a_pair_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_pair_start |=> busy && !result_valid)
		else $error("Pair op did not raise busy");
	a_and_keeps_c: assert property (@(posedge clk_sys) disable iff (!rst_n)
		start && clk_en && !busy && op == bal_pkg::OP_AND |=> $stable(flags[bal_pkg::FLAG_C]) && !flags[bal_pkg::FLAG_V])
		else $error("AND touched carry or left V set");
	a_xor_result: assert property (@(posedge clk_sys) disable iff (!rst_n)
		start && clk_en && !busy && op == bal_pkg::OP_EXCLUSIVE_DISJUNCTION |=> result == ($past(dest_reg) ^ $past(source_reg)))
		else $error("XOR result wrong");
	a_invert_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
		start && clk_en && !busy && op == bal_pkg::OP_INVERT_ALL_BITS |=> result == ~$past(dest_reg) && flags[bal_pkg::FLAG_C])
		else $error("Invert wrong");
	a_zero_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
		result_valid && !result_pair |-> flags[bal_pkg::FLAG_Z] == (result == 8'h00) && flags[bal_pkg::FLAG_N] == result[7])
		else $error("Z or N flag mismatch");
endmodule // bal_core

// >>> bal_decoder_model.sv
`timescale 1ns/1ps
// Decoder side: one request register, stalled while the unit is busy
module bal_decoder_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic busy,
	input wire logic go,
	input wire logic [4:0] op_in,
	input wire logic [7:0] d_in,
	input wire logic [7:0] s_in,
	input wire logic [7:0] h_in,
	input wire logic [7:0] k_in,
	output logic start,
	output logic [4:0] op,
	output logic [7:0] dest_reg,
	output logic [7:0] source_reg,
	output logic [7:0] dest_high_reg,
	output logic [7:0] immediate
);
	// Operands load on every enabled cycle while not busy, and hold their old values through busy or disabled cycles
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			start <= 1'b0;
			op <= 5'h00;
		end else if (clk_en && !busy) begin
			start <= go;
			op <= op_in;
			dest_reg <= d_in;
			source_reg <= s_in;
			dest_high_reg <= h_in;
			immediate <= k_in;
		end
	end
endmodule // bal_decoder_model

// >>> bal_pkg.sv
package bal_pkg;

	localparam int DATA_W = 8;
	localparam int WORD_W = 16;
	localparam int OP_W = 5;

	// Cycles each operation class occupies
	localparam int BYTE_OP_CYCLES = 1;
	localparam int PAIR_OP_CYCLES = 2;

	// Flag positions in the status byte
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;

	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] ALL_ONES = 8'hFF;

	// Operation codes presented by the decoder
	localparam logic [OP_W-1:0] OP_ADD = 5'h00;
	localparam logic [OP_W-1:0] OP_ADD_CARRY = 5'h01;
	localparam logic [OP_W-1:0] OP_PAIR_INCREMENT_BY_IMM = 5'h02;
	localparam logic [OP_W-1:0] OP_SUB = 5'h03;
	localparam logic [OP_W-1:0] OP_DIFFERENCE_IMMEDIATE = 5'h04;
	localparam logic [OP_W-1:0] OP_DIFFERENCE_MINUS_CARRY = 5'h05;
	localparam logic [OP_W-1:0] OP_DIFFERENCE_IMM_MINUS_CARRY = 5'h06;
	localparam logic [OP_W-1:0] OP_PAIR_DECREMENT_BY_IMM = 5'h07;
	localparam logic [OP_W-1:0] OP_AND = 5'h08;
	localparam logic [OP_W-1:0] OP_CONJUNCTION_IMMEDIATE = 5'h09;
	localparam logic [OP_W-1:0] OP_OR = 5'h0A;
	localparam logic [OP_W-1:0] OP_DISJUNCTION_IMMEDIATE = 5'h0B;
	localparam logic [OP_W-1:0] OP_EXCLUSIVE_DISJUNCTION = 5'h0C;
	localparam logic [OP_W-1:0] OP_INVERT_ALL_BITS = 5'h0D;

	typedef enum logic [1:0] {
		BAL_IDLE,
		BAL_PAIR_HIGH
	} bal_state_e;

endpackage

// >>> byte_alu_arith_logic_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module byte_alu_arith_logic_bench;
	logic clk_sys = 0, rst_n = 0, clk_en = 0, go = 0, start, busy, result_valid, result_pair;
	logic [4:0] op_in = 0, op;
	logic [7:0] d_in = 0, s_in = 0, h_in = 0, k_in = 0, dest_reg, source_reg, dest_high_reg, immediate;
	logic [7:0] result, result_high, flags, fl = 0;
	logic [15:0] ecnt = 0;
	logic [40:0] exp_q[$];
	logic [40:0] note;
	int seed = 15, miscompares = 0, tests_run = 0;
	initial forever #25 clk_sys = ~clk_sys;
	bal_decoder_model i_bal_decoder_model(.clk_sys, .rst_n, .clk_en, .busy, .go, .op_in, .d_in, .s_in,
		.h_in, .k_in, .start, .op, .dest_reg, .source_reg, .dest_high_reg, .immediate);
	bal_core i_bal_core(.clk_sys, .rst_n, .clk_en, .start, .op, .dest_reg, .source_reg, .dest_high_reg,
		.immediate, .result, .result_high, .result_valid, .result_pair, .busy, .flags);
	// Enabled edges only; answers are timed against this count
	always @(posedge clk_sys) if (clk_en) ecnt <= ecnt + 16'h1;
	always @(posedge clk_sys) begin
		if (rst_n && clk_en && result_valid === 1'b1) begin
			// An answer nobody asked for meets an all-ones note and fails
			if (exp_q.size() == 0) exp_q.push_back('1);
			// Pop once: the macro names its expected value twice
			note = exp_q.pop_front();
			`CHK({ecnt, result_pair, result_pair ? result_high : 8'h00, result, flags}, note)
			`CHK(busy, 1'b0)
		end
	end
	task automatic idle();
		logic en;
		do begin
			en = $random(seed) % 4 != 0;
			clk_en <= en;
			go <= 1'b0;
			d_in <= $random(seed);
			@(posedge clk_sys);
		end while (!en);
	endtask
	task automatic issue(input logic [4:0] o);
		logic [7:0] d, s, h, k, b, r, rh;
		logic [16:0] w;
		logic c, hc, v, sg, cin, en, pr, ok, inc;
		d = $random(seed);
		s = $random(seed);
		h = $random(seed);
		k = $random(seed);
		b = o inside {bal_pkg::OP_DIFFERENCE_IMMEDIATE, bal_pkg::OP_DIFFERENCE_IMM_MINUS_CARRY,
			bal_pkg::OP_CONJUNCTION_IMMEDIATE, bal_pkg::OP_DISJUNCTION_IMMEDIATE} ? k : s;
		cin = fl[0] & (o inside {bal_pkg::OP_ADD_CARRY, bal_pkg::OP_DIFFERENCE_MINUS_CARRY,
			bal_pkg::OP_DIFFERENCE_IMM_MINUS_CARRY});
		inc = o == bal_pkg::OP_PAIR_INCREMENT_BY_IMM;
		c = fl[0];
		hc = fl[5];
		sg = fl[4];
		v = 1'b0;
		pr = 1'b0;
		rh = 8'h00;
		ok = 1'b1;
		case (o)
			bal_pkg::OP_ADD, bal_pkg::OP_ADD_CARRY: begin
				{c, r} = d + b + cin;
				hc = d[3:0] + b[3:0] + cin > 15;
				v = d[7] == b[7] && r[7] != d[7];
			end
			bal_pkg::OP_SUB, bal_pkg::OP_DIFFERENCE_MINUS_CARRY, bal_pkg::OP_DIFFERENCE_IMMEDIATE,
			bal_pkg::OP_DIFFERENCE_IMM_MINUS_CARRY: begin
				{c, r} = {1'b0, d} - b - cin;
				hc = d[3:0] < {1'b0, b[3:0]} + cin;
				v = d[7] != b[7] && r[7] != d[7];
			end
			bal_pkg::OP_AND, bal_pkg::OP_CONJUNCTION_IMMEDIATE: r = d & b;
			bal_pkg::OP_OR, bal_pkg::OP_DISJUNCTION_IMMEDIATE: r = d | b;
			bal_pkg::OP_EXCLUSIVE_DISJUNCTION: r = d ^ b;
			bal_pkg::OP_INVERT_ALL_BITS: begin
				r = ~d;
				c = 1'b1;
			end
			bal_pkg::OP_PAIR_INCREMENT_BY_IMM, bal_pkg::OP_PAIR_DECREMENT_BY_IMM: begin
				pr = 1'b1;
				w = inc ? {1'b0, h, d} + k : {1'b0, h, d} - k;
				{c, rh, r} = w;
				v = inc ? !h[7] && rh[7] : h[7] && !rh[7];
				sg = rh[7] ^ v;
			end
			default: ok = 1'b0;
		endcase
		if (ok) fl = {2'b00, hc, sg, v, pr ? rh[7] : r[7], {rh, r} == 16'h0, c};
		do begin
			en = $random(seed) % 4 != 0;
			clk_en <= en;
			go <= 1'b1;
			op_in <= o;
			d_in <= d;
			s_in <= s;
			h_in <= h;
			k_in <= k;
			@(posedge clk_sys);
		end while (!en);
		if (ok) exp_q.push_back({ecnt + (pr ? 16'h3 : 16'h2), pr, rh, r, fl});
		// Pair ops need the busy cycle to pass before the next request
		if (pr) repeat (2) idle();
	endtask
	task results();
		$display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
		if (miscompares == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		`CHK({result, result_high, result_valid, result_pair, busy, flags}, 27'h0)
		@(posedge clk_sys);
		rst_n <= 1'b1;
		// Code 14 is unassigned and must give no answer
		for (int i = 0; i < 450; i++) issue(5'(i % 15));
		repeat (4) idle();
		`CHK(exp_q.size(), 0)
		results();
	end
	initial begin
		#500us;
		miscompares++;
		results();
	end
endmodule // byte_alu_arith_logic_bench
